// [design/psbc_regs.svh]
// Purpose: constants for the processor-side bus cycle engine
// Assumes: included by design files only
// Notes: widths, opcodes and cycle counts
`ifndef PSBC_REGS_SVH
`define PSBC_REGS_SVH
`define PSBC_ADDR_W 16
`define PSBC_DATA_W 8
`define PSBC_FLOAT_BYTE 8'hff
`define PSBC_CALL_OP 8'hcd
`define PSBC_STROBE_CYC 3'h2
`endif

// [design/psbc_pkg.sv]
// Purpose: types for the processor-side bus cycle engine
// Assumes: nothing
// Notes: cycle kinds and request carrier
package psbc_pkg;
	typedef enum logic [2:0] {
		PSBC_MEM_RD = 3'h0,
		PSBC_MEM_WR = 3'h1,
		PSBC_IO_IN = 3'h2,
		PSBC_IO_OUT = 3'h3,
		PSBC_INTA = 3'h4,
		PSBC_HALT = 3'h5
	} psbc_kind_t;
	typedef struct packed {
		psbc_kind_t kind;
		logic [15:0] addr;
		logic [7:0] wdata;
	} psbc_req_t;
endpackage

// [design/psbc_sync.sv]
// Purpose: three-stage synchroniser with agreement filter
// Assumes: asynchronous input level
// Notes: stage one feeds stage two only
`timescale 1ns/1ns
module psbc_sync (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// level in and out
	input wire logic din,
	output logic dout
);
	logic s1_r;
	logic s2_r;
	logic s3_r;
	logic dout_r;

	// three stage flops and an output flop; change counts once stages two and three agree
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
			dout_r <= 1'b0;
		end else begin
			s1_r <= din;
			s2_r <= s1_r;
			s3_r <= s2_r;
			if (s2_r == s3_r) begin
				dout_r <= s3_r;
			end
		end
	end
	assign dout = dout_r;
endmodule

// [design/psbc_master.sv]
// Purpose: processor-side engine for the parallel backplane bus cycles
// Assumes: one clock; boards answer within the strobe window
// Notes: undriven inbound lines read as all ones
`timescale 1ns/1ns
`include "psbc_regs.svh"
module psbc_master (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// core request side
	input wire logic req_valid,
	input wire psbc_pkg::psbc_req_t req,
	output logic req_ready,
	output logic done,
	output logic [7:0] rdata,
	// interrupt side
	input wire logic int_enable,
	input wire logic [15:0] cur_pc,
	output logic int_taken,
	output logic [15:0] saved_pc,
	// bus pins from boards
	input wire logic [7:0] bus_din,
	input wire logic bus_din_driven,
	input wire logic bus_int_req,
	input wire logic bus_hold_req,
	// bus pins to boards
	output logic [15:0] bus_addr,
	output logic [7:0] bus_dout,
	output logic bus_drv_en,
	output logic bus_dbin,
	output logic bus_wr_n,
	output logic [2:0] bus_kind,
	output logic bus_hlda
);
	// one-hot states: idle, strobing, bus lent out, closing
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_ACT = 4'b0010,
		ST_HOLD = 4'b0100,
		ST_DONE = 4'b1000
	} psbc_state_t;

	// cycle registers and synchronised pin levels
	psbc_state_t state_r;
	psbc_state_t state_nxt;
	psbc_pkg::psbc_req_t cur_r;
	logic [2:0] cnt_r;
	logic [7:0] rdata_r;
	logic [15:0] addr_r;
	logic [7:0] dout_r;
	logic [15:0] saved_pc_r;
	logic int_taken_r;
	logic int_s;
	logic hold_s;
	logic start;
	logic is_read;
	psbc_pkg::psbc_req_t start_req;

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers
	// interrupt and hold come from other boards, so both are filtered
	psbc_sync u_int_sync (
		.core_clk(core_clk),
		.rst(rst),
		.din(bus_int_req),
		.dout(int_s)
	);
	psbc_sync u_hold_sync (
		.core_clk(core_clk),
		.rst(rst),
		.din(bus_hold_req),
		.dout(hold_s)
	);

	////////////////////////////////////////////////////////////////////////
	// address for a cycle kind
	function automatic logic [15:0] cyc_addr(input psbc_pkg::psbc_req_t r);
		if (r.kind == psbc_pkg::PSBC_IO_IN || r.kind == psbc_pkg::PSBC_IO_OUT) begin
			cyc_addr = {r.addr[7:0], r.addr[7:0]};
		end else begin
			cyc_addr = r.addr;
		end
	endfunction

	// cycle kinds that strobe the inbound path
	function automatic logic kind_reads(input psbc_pkg::psbc_kind_t k);
		kind_reads = (k == psbc_pkg::PSBC_MEM_RD) || (k == psbc_pkg::PSBC_IO_IN) ||
			(k == psbc_pkg::PSBC_INTA);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// start selection: interrupt wins over a fresh request
	// limitation: a request still high after its cycle is taken again; the core drops enable
	always_comb begin
		start_req = req;
		if (int_s && int_enable) begin
			start_req.kind = psbc_pkg::PSBC_INTA;
			start_req.addr = cur_pc;
			start_req.wdata = 8'h00;
		end
	end
	// hold is granted only between cycles, so a cycle never tears
	assign start = (state_r == ST_IDLE) && !hold_s && (req_valid || (int_s && int_enable));
	assign req_ready = (state_r == ST_IDLE) && !hold_s && !(int_s && int_enable);
	assign is_read = kind_reads(cur_r.kind);

	////////////////////////////////////////////////////////////////////////
	// next state
	// the done cycle gives the core one clear edge before the next start
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE: begin
				if (hold_s) begin
					state_nxt = ST_HOLD;
				end else if (start) begin
					state_nxt = ST_ACT;
				end
			end
			ST_ACT: begin
				if (cnt_r == `PSBC_STROBE_CYC) begin
					state_nxt = ST_DONE;
				end
			end
			ST_HOLD: begin
				if (!hold_s) begin
					state_nxt = ST_IDLE;
				end
			end
			ST_DONE: state_nxt = ST_IDLE;
			default: state_nxt = ST_IDLE;
		endcase
	end

	// state register
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state_r <= ST_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// strobe-width counter
	// one shared constant sets the window, so capture and strobes stay aligned
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cnt_r <= 3'h0;
		end else if (state_r == ST_ACT) begin
			cnt_r <= cnt_r + 3'h1;
		end else begin
			cnt_r <= 3'h0;
		end
	end

	// latch request and drive address/data for the cycle
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cur_r <= '0;
			addr_r <= 16'h0000;
			dout_r <= 8'h00;
		end else if (start) begin
			cur_r <= start_req;
			addr_r <= cyc_addr(start_req);
			dout_r <= start_req.wdata;
		end
	end

	// capture inbound byte at end of strobe
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			rdata_r <= 8'h00;
		end else if (state_r == ST_ACT && cnt_r == `PSBC_STROBE_CYC && is_read) begin
			// undriven lines pull up, so interrupt with no vector gives restart 7
			rdata_r <= bus_din_driven ? bus_din : `PSBC_FLOAT_BYTE;
		end
	end

	// save program location on interrupt acknowledge
	// pc is taken at start, so a pc that moves meanwhile cannot skew it
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			saved_pc_r <= 16'h0000;
			int_taken_r <= 1'b0;
		end else begin
			int_taken_r <= 1'b0;
			if (state_r == ST_ACT && cnt_r == `PSBC_STROBE_CYC && cur_r.kind == psbc_pkg::PSBC_INTA) begin
				saved_pc_r <= cur_r.addr;
				int_taken_r <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pin outputs; all groups float in hold
	// strobes decode from registers only, so request inputs cannot glitch them
	assign bus_hlda = (state_r == ST_HOLD);
	assign bus_drv_en = (state_r != ST_HOLD);
	assign bus_addr = addr_r;
	assign bus_dout = dout_r;
	assign bus_kind = cur_r.kind;
	assign bus_dbin = (state_r == ST_ACT) && is_read;
	assign bus_wr_n = !((state_r == ST_ACT) && (cur_r.kind == psbc_pkg::PSBC_MEM_WR ||
		cur_r.kind == psbc_pkg::PSBC_IO_OUT));
	assign done = (state_r == ST_DONE);
	assign rdata = rdata_r;
	assign int_taken = int_taken_r;
	assign saved_pc = saved_pc_r;
endmodule

// [test/psbc_checker.sv]
// Purpose: bus cycle checker
// Assumes: bound to psbc_master
// Notes: one clock domain
`timescale 1ns/1ns
module psbc_checker (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// request side
	input wire logic req_valid,
	input wire psbc_pkg::psbc_req_t req,
	input wire logic req_ready,
	input wire logic done,
	input wire logic int_enable,
	input wire logic int_taken,
	// bus side
	input wire logic [15:0] bus_addr,
	input wire logic [7:0] bus_dout,
	input wire logic bus_drv_en,
	input wire logic bus_dbin,
	input wire logic bus_wr_n,
	input wire logic [2:0] bus_kind,
	input wire logic bus_hlda
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	// a request taken this edge
	wire acc = req_valid && req_ready;
	////////////////////////////////////////////////////////////////
	a_done_four: assert property (acc |-> ##4 done)
		else $error("done late");
	a_mem_addr: assert property (acc && req.kind == psbc_pkg::PSBC_MEM_RD |-> ##1 bus_addr == $past(req.addr))
		else $error("bad address");
	a_wr_data: assert property (acc && req.kind == psbc_pkg::PSBC_MEM_WR |-> ##2 bus_dout == $past(req.wdata, 2))
		else $error("bad write byte");
	a_port_dup: assert property (bus_kind inside {3'h2, 3'h3} && (bus_dbin || !bus_wr_n) |->
		bus_addr[15:8] == bus_addr[7:0])
		else $error("port halves differ");
	a_read_kind: assert property (bus_dbin |-> bus_kind inside {3'h0, 3'h2, 3'h4})
		else $error("read strobe kind");
	a_write_len: assert property ($fell(bus_wr_n) |-> (bus_kind inside {3'h1, 3'h3} && !bus_wr_n) [*3] ##1 bus_wr_n)
		else $error("write strobe");
	a_hold_off: assert property (bus_hlda |-> !bus_drv_en && !req_ready)
		else $error("bus kept in hold");
	a_int_mask: assert property (!int_enable [*8] |-> !int_taken)
		else $error("masked interrupt taken");
	a_int_kind: assert property (int_taken |-> bus_kind == 3'h4)
		else $error("interrupt kind");
	// main scenarios reached
	c_write: cover property (!bus_wr_n && bus_kind == 3'h1);
	c_port_in: cover property (bus_dbin && bus_kind == 3'h2);
	c_hold: cover property (bus_hlda);
endmodule
bind psbc_master psbc_checker psbc_checker_i (.core_clk, .rst, .req_valid, .req, .req_ready, .done, .int_enable,
	.int_taken, .bus_addr, .bus_dout, .bus_drv_en, .bus_dbin, .bus_wr_n, .bus_kind, .bus_hlda);

// [test/psbc_board.sv]
// Purpose: memory and port boards
// Assumes: strobes from psbc_master
// Notes: released path shows inverse of last byte
`timescale 1ns/1ns
module psbc_board (
	// clock
	input wire logic core_clk,
	// from the bus master
	input wire logic [15:0] bus_addr,
	input wire logic [7:0] bus_dout,
	input wire logic bus_dbin,
	input wire logic bus_wr_n,
	input wire logic [2:0] bus_kind,
	// inbound path
	output logic [7:0] bus_din,
	output logic bus_din_driven
);
	logic [7:0] mem [256];
	logic [7:0] last_r = 8'h00;
	wire sel = bus_dbin && (bus_kind == 3'h0 || bus_kind == 3'h2);
	// answer only when selected, so a stale byte never passes
	always_comb begin
		bus_din_driven = sel;
		bus_din = ~last_r;
		if (sel)
			bus_din = bus_kind == 3'h0 ? mem[bus_addr[7:0]] : bus_addr[7:0] ^ 8'h5a;
	end
	// capture stores; only low address byte decoded
	always @(posedge core_clk) begin
		if (sel)
			last_r <= bus_din;
		if (!bus_wr_n && bus_kind == 3'h1)
			mem[bus_addr[7:0]] <= bus_dout;
	end
endmodule

// [test/tb_top.sv]
// Purpose: bus cycle testbench
// Assumes: board model on the far side
// Notes: fixed seed
`timescale 1ns/1ns
module tb_top;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic req_valid = 1'b0;
	psbc_pkg::psbc_req_t req = '0;
	logic int_enable = 1'b0;
	logic [15:0] cur_pc = 16'h0000;
	logic bus_int_req = 1'b0;
	logic bus_hold_req = 1'b0;
	logic req_ready, done, int_taken, bus_din_driven, bus_drv_en, bus_dbin, bus_wr_n, bus_hlda;
	logic [7:0] rdata, bus_din, bus_dout;
	logic [15:0] saved_pc, bus_addr, a;
	logic [2:0] bus_kind;
	logic [7:0] d;
	integer fail_count = 0;
	integer n_tests = 0;
	integer seed = 32'h09f8;
	integer i;
	always #20 core_clk = ~core_clk;
	psbc_master psbc_master_i (.core_clk, .rst, .req_valid, .req, .req_ready, .done, .rdata, .int_enable, .cur_pc,
		.int_taken, .saved_pc, .bus_din, .bus_din_driven, .bus_int_req, .bus_hold_req, .bus_addr, .bus_dout,
		.bus_drv_en, .bus_dbin, .bus_wr_n, .bus_kind, .bus_hlda);
	psbc_board psbc_board_i (.core_clk, .bus_addr, .bus_dout, .bus_dbin, .bus_wr_n, .bus_kind, .bus_din,
		.bus_din_driven);
	////////////////////////////////////////////////////////////////
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d errors %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// expected port values worked out from the rules
	function automatic logic [15:0] port_addr(input logic [15:0] p);
		port_addr = {p[7:0], p[7:0]};
	endfunction
	function automatic logic [15:0] port_in_exp(input logic [15:0] p);
		port_in_exp = {8'h00, p[7:0] ^ 8'h5a};
	endfunction
	// flag picked by number: 0 ready, 1 done, 2 interrupt taken, 3 hold granted
	function automatic logic flag_of(input integer which);
		case (which)
			0: flag_of = req_ready;
			1: flag_of = done;
			2: flag_of = int_taken;
			default: flag_of = bus_hlda;
		endcase
	endfunction
	// bounded wait; a hang ends the run
	task automatic wait_for(input integer which);
		integer n;
		n = 0;
		while (flag_of(which) !== 1'b1) begin
			@(posedge core_clk);
			#1;
			n++;
			if (n > 60) begin
				fail_count++;
				print_verdict();
			end
		end
	endtask
	task automatic run(input logic [2:0] kind, input logic [15:0] ad, input logic [7:0] wd);
		@(posedge core_clk);
		req_valid <= 1'b1;
		req <= '{psbc_pkg::psbc_kind_t'(kind), ad, wd};
		#1;
		wait_for(0);
		@(posedge core_clk);
		req_valid <= 1'b0;
		#1;
		wait_for(1);
	endtask
	////////////////////////////////////////////////////////////////
	// random cycles with address corners first
	initial begin
		repeat (10) @(posedge core_clk);
		rst <= 1'b0;
		for (i = 0; i < 40; i++) begin
			a = 16'($random(seed));
			d = 8'($random(seed));
			if (i < 2)
				a = {16{i[0]}};
			run(3'h1, a, d);
			run(3'h0, a, 8'h00);
			check("mem read", rdata, d);
			run(3'h2, a, 8'h00);
			check("port in", rdata, port_in_exp(a));
			run(3'h3, a, d);
			check("port out", bus_dout, d);
			check("port addr", bus_addr, port_addr(a));
		end
		run(3'h5, a, 8'h00);
		check("halt kind", bus_kind, psbc_pkg::PSBC_HALT);
		// masked request first, settled through the filter, then enabled
		@(posedge core_clk);
		bus_int_req <= 1'b1;
		repeat (6) @(posedge core_clk);
		run(3'h0, a, 8'h00);
		check("masked read", rdata, d);
		@(posedge core_clk);
		int_enable <= 1'b1;
		cur_pc <= 16'h1234;
		#1;
		wait_for(2);
		check("saved pc", saved_pc, 16'h1234);
		check("vector", rdata, 8'hff);
		@(posedge core_clk);
		int_enable <= 1'b0;
		bus_int_req <= 1'b0;
		bus_hold_req <= 1'b1;
		#1;
		wait_for(3);
		check("drive enable", bus_drv_en, 1'b0);
		@(posedge core_clk);
		bus_hold_req <= 1'b0;
		run(3'h0, a, 8'h00);
		check("after hold", rdata, d);
		check("drive back", bus_drv_en, 1'b1);
		print_verdict();
	end
endmodule
